// >>> cbes_top.sv
// Purpose: Enable sequencing of a clock fan-out buffer with an output divider.
// Assumes: All inputs are synchronous to clock_i; clock_in_i is the sampled input clock.
// Notes: Tri-state pins appear as value plus output enable; the bench checks the value and the enable separately.
`default_nettype none
// Overview of operation
// - Enable low puts every driver high-impedance.
// - Disabled: select inputs ignored and powered down.
// - Disabled: all flip-flops and divider held reset, except the enable and input clock latches, which still follow enable_i and clock_in_i.
// - After enable, settle at most 1 us.
// - Settling: differential legs high, single-ended undefined.
// - After settling, outputs go low first.
// - Output transitions resynchronized to input clock edges.
// - Single stage enabled: true leg starts undefined.
// - Complementary leg inverse of true leg, except both high while settling.
// - Undivided output follows input at first rise.
// - Newly enabled driver shows running divider state.
// - Driver enable never resets the divider.
// - Latched falling enable turns outputs off quickly.
module cbes_top #(
  parameter int unsigned SETTLE_CYC = cbes_pkg::SETTLE_CYCLES,
  parameter int unsigned DIV_W = cbes_pkg::DIV_W
) (
  input wire logic clock_i, // System clock, 20 MHz.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic enable_i, // Global output enable.
  input wire logic clock_in_i, // Sampled buffered input clock level.
  input wire logic [1:0] output_mode_select_low, // Three-level select code.
  input wire logic [1:0] output_mode_select_high, // Three-level select code.
  output logic diff_clock_out_true, // Differential true leg.
  output logic diff_clock_out_comp, // Differential complementary leg.
  output logic diff_oe_o, // Differential driver enable.
  output logic single_ended_clock_out, // Single-ended output.
  output logic se_oe_o, // Single-ended driver enable.
  output logic settling_o // Settling interval in progress.
);
  typedef struct packed {
    cbes_pkg::cbes_state_type st;
    logic [cbes_pkg::CNT_W-1:0] cnt;
    logic en_l;
    logic clk_l;
    logic [1:0] sel_lo;
    logic [1:0] sel_hi;
    logic yt;
    logic yc;
    logic doe;
    logic ys;
    logic soe;
    logic settle;
  } cbes_top_type;

  cbes_top_type s_q;
  cbes_top_type s_d;
  logic [DIV_W-1:0] div_cnt;
  logic div_clear;
  logic rise;
  logic [DIV_W-1:0] div_nxt;
  localparam int SETTLE_BOUND = int'(SETTLE_CYC);

  // Selected output level per mode; in the run state a high select disables that driver.
  function automatic logic pick(input logic [1:0] sel, input logic clk,
                                input logic [DIV_W-1:0] cnt);
    logic r;
    r = clk;
    unique case (sel)
      cbes_pkg::SEL_LOW: r = clk;
      cbes_pkg::SEL_MID: r = cnt[0];
      default: r = cnt[1];
    endcase
    return r;
  endfunction

  function automatic logic drv_on(input logic [1:0] sel);
    return sel != cbes_pkg::SEL_HIGH;
  endfunction

  assign rise = clock_in_i & ~s_q.clk_l & (s_q.st == cbes_pkg::ST_RUN);
  assign div_clear = ~s_q.en_l;
  // A divided output shows the count that the divider takes at this very edge, so a
  // driver that joins later sees the same state as one that has been running.
  assign div_nxt = div_cnt + {{(DIV_W-1){1'b0}}, rise};

  cbes_divider #(
    .DIV_W(DIV_W)
  ) i_cbes_divider (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .clear_i(div_clear),
    .rise_i(rise),
    .count_o(div_cnt)
  );

  always_comb begin
    s_d = s_q;
    s_d.en_l = enable_i;
    s_d.clk_l = clock_in_i;
    if (!s_q.en_l) begin
      s_d.st = cbes_pkg::ST_OFF;
      s_d.cnt = '0;
      s_d.sel_lo = cbes_pkg::SEL_LOW;
      s_d.sel_hi = cbes_pkg::SEL_LOW;
      s_d.doe = 1'b0;
      s_d.soe = 1'b0;
      s_d.yt = 1'b0;
      s_d.yc = 1'b1;
      s_d.ys = 1'b0;
      s_d.settle = 1'b0;
    end else begin
      unique case (s_q.st)
        cbes_pkg::ST_OFF: begin
          s_d.st = cbes_pkg::ST_SETTLE;
          s_d.cnt = '0;
          s_d.settle = 1'b1;
          s_d.doe = 1'b1;
          s_d.soe = 1'b1;
          s_d.yt = 1'b1;
          s_d.yc = 1'b1;
        end
        cbes_pkg::ST_SETTLE: begin
          s_d.cnt = s_q.cnt + 8'h01;
          if (32'(s_q.cnt) + 32'd2 >= SETTLE_CYC) begin
            s_d.st = cbes_pkg::ST_LOW;
            s_d.settle = 1'b0;
            s_d.yt = 1'b0;
            s_d.yc = 1'b1;
            s_d.ys = 1'b0;
          end
        end
        cbes_pkg::ST_LOW: begin
          s_d.st = cbes_pkg::ST_RUN;
          s_d.sel_lo = output_mode_select_low;
          s_d.sel_hi = output_mode_select_high;
        end
        cbes_pkg::ST_RUN: begin
          s_d.sel_lo = output_mode_select_low;
          s_d.sel_hi = output_mode_select_high;
          s_d.doe = drv_on(s_q.sel_lo);
          s_d.soe = drv_on(s_q.sel_hi);
          // Levels change on latched input clock edges, and when a driver turns on.
          // A driver that just turned on shows the running divider at once, and it
          // still takes an input edge that falls in the same cycle.
          if (s_d.clk_l != s_q.clk_l || (!s_q.doe && drv_on(s_q.sel_lo))) begin
            s_d.yt = pick(s_q.sel_lo, s_d.clk_l, div_nxt);
          end
          if (s_d.clk_l != s_q.clk_l || (!s_q.soe && drv_on(s_q.sel_hi))) begin
            s_d.ys = pick(s_q.sel_hi, s_d.clk_l, div_nxt);
          end
          s_d.yc = ~s_d.yt;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q <= '{st: cbes_pkg::ST_OFF, cnt: '0, en_l: 1'b0, clk_l: 1'b0,
               sel_lo: cbes_pkg::SEL_LOW, sel_hi: cbes_pkg::SEL_LOW,
               yt: 1'b0, yc: 1'b1, doe: 1'b0, ys: 1'b0, soe: 1'b0, settle: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign diff_clock_out_true = s_q.yt;
  assign diff_clock_out_comp = s_q.yc;
  assign diff_oe_o = s_q.doe;
  assign single_ended_clock_out = s_q.ys;
  assign se_oe_o = s_q.soe;
  assign settling_o = s_q.settle;

  a_off_hiz: assert property (@(posedge clock_i) disable iff (reset_i)
    !s_q.en_l |=> !diff_oe_o && !se_oe_o) else $error("drivers on while disabled");
  a_div_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    !s_q.en_l |=> div_cnt == '0) else $error("divider not reset");
  a_settle_len: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(settling_o) |-> ##[1:SETTLE_BOUND] !settling_o) else $error("settle length");
  a_settle_high: assert property (@(posedge clock_i) disable iff (reset_i)
    settling_o |-> diff_clock_out_true && diff_clock_out_comp) else $error("legs not high");
  a_low_after: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(settling_o) && s_q.en_l |-> !diff_clock_out_true && !single_ended_clock_out)
    else $error("not low after settle");
  a_comp_inv: assert property (@(posedge clock_i) disable iff (reset_i)
    s_q.st == cbes_pkg::ST_RUN |-> diff_clock_out_comp == !diff_clock_out_true)
    else $error("comp not inverse");
  a_pass_follow: assert property (@(posedge clock_i) disable iff (reset_i)
    $changed(s_q.clk_l) && $past(s_q.st) == cbes_pkg::ST_RUN && $past(s_q.en_l) &&
    $past(s_q.sel_lo) == cbes_pkg::SEL_LOW |-> diff_clock_out_true == s_q.clk_l)
    else $error("undivided output not following input");
  a_sel_latch: assert property (@(posedge clock_i) disable iff (reset_i)
    s_q.st == cbes_pkg::ST_RUN && s_q.en_l |=>
    s_q.sel_lo == $past(output_mode_select_low) && s_q.sel_hi == $past(output_mode_select_high))
    else $error("select not latched");
  a_sel_ignored: assert property (@(posedge clock_i) disable iff (reset_i)
    !s_q.en_l |=> s_q.sel_lo == cbes_pkg::SEL_LOW) else $error("select used while off");
  a_off_fast: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(s_q.en_l) |=> s_q.st == cbes_pkg::ST_OFF) else $error("slow turn off");
  a_div_keep: assert property (@(posedge clock_i) disable iff (reset_i)
    ($rose(diff_oe_o) || $rose(se_oe_o)) && $past(s_q.st) == cbes_pkg::ST_RUN |->
    div_cnt == ($past(rise) ? $past(div_cnt) + {{(DIV_W-1){1'b0}}, 1'b1} : $past(div_cnt)))
    else $error("divider restarted");
  c_se_join: cover property (@(posedge clock_i) $rose(se_oe_o) && s_q.st == cbes_pkg::ST_RUN);
  c_enable_seq: cover property (@(posedge clock_i) $fell(settling_o) ##2 s_q.st == cbes_pkg::ST_RUN);
  c_disable: cover property (@(posedge clock_i) s_q.st == cbes_pkg::ST_RUN ##1 !s_q.en_l);
  c_div_run: cover property (@(posedge clock_i) rise && s_q.sel_lo == cbes_pkg::SEL_MID);
endmodule
`default_nettype wire

// >>> cbes_pkg.sv
// Purpose: Shared constants and types for the clock buffer enable sequencer.
// Assumes: A 20 MHz system clock stands for the sampled input clock domain.
// Notes: Mode-select encoding is a plain two-bit code per three-level input.
`default_nettype none
package cbes_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Longest settling interval after enable, in nanoseconds (rounded down).
  localparam int unsigned SETTLE_MAX_NS = 1000;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (SETTLE_MAX_NS / CLK_PERIOD_NS);
  // Typical turn-off time once a falling enable is latched, in nanoseconds.
  localparam int unsigned DISABLE_TYP_NS = 10;
  localparam int unsigned DISABLE_CYCLES =
    (DISABLE_TYP_NS / CLK_PERIOD_NS) < 1 ? 1 : (DISABLE_TYP_NS / CLK_PERIOD_NS);
  localparam int unsigned CNT_W = 8;
  localparam int unsigned DIV_W = 4;
  // Each three-level select input arrives as a two-bit code: low, mid, high.
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_MID = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_SETTLE,
    ST_LOW,
    ST_RUN
  } cbes_state_type;
endpackage
`default_nettype wire

// >>> cbes_divider.sv
// Purpose: Free-running output divider for the buffered clock.
// Assumes: Count advances on each rising edge of the sampled input clock seen in the run state.
// Notes: Only reset and the clear input restart the count; driver enables never do.
`default_nettype none
module cbes_divider #(
  parameter int unsigned DIV_W = cbes_pkg::DIV_W
) (
  input wire logic clock_i, // System clock.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic clear_i, // Hold count at zero.
  input wire logic rise_i, // Rising input clock edge seen.
  output logic [DIV_W-1:0] count_o // Current divider state.
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } cbes_div_type;
  cbes_div_type s_q;
  cbes_div_type s_d;

  always_comb begin
    s_d = s_q;
    if (clear_i) begin
      s_d.cnt = cbes_pkg::DIV_RESET;
    end else if (rise_i) begin
      s_d.cnt = s_q.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.cnt;
endmodule
`default_nettype wire

// >>> cbes_clk_src.sv
// Purpose: Free-running model of the clock source that feeds the buffer input.
// Assumes: Levels change just after the falling edge of the system clock.
// Notes: The source runs free, as a buffer input clock does in a real system.
`default_nettype none
module cbes_clk_src #(
  parameter int unsigned HALF_CYC = 4
) (
  input wire logic clock_i, // System clock.
  output logic clock_in_o // Input clock level towards the buffer.
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;
  initial clock_in_o = 1'b0;
  // Changing on the falling edge keeps a clean setup before each sampling edge.
  always @(negedge clock_i) begin
    if (cnt == HALF_CYC - 1) begin
      cnt <= 0;
      clock_in_o <= ~clock_in_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// >>> cbes_top_tb.sv
// Purpose: Self-checking bench for the enable sequencing of the clock buffer.
// Assumes: Settling is shortened to at most four cycles; the source half period is four cycles.
// Notes: Outputs are sampled on the falling edge, where they have settled.
`default_nettype none
module cbes_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SET_CYC = 4;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic enable_i = 1'b0;
  logic clock_in_i;
  logic [1:0] sel_lo = cbes_pkg::SEL_LOW;
  logic [1:0] sel_hi = cbes_pkg::SEL_LOW;
  logic d_true, d_comp, d_oe, se_out, se_oe, settling;
  int error_cnt = 0;
  int total_checks = 0;
  always #25 clock_i = ~clock_i;
  cbes_clk_src #(.HALF_CYC(4)) i_cbes_clk_src (.clock_i(clock_i), .clock_in_o(clock_in_i));
  cbes_top #(.SETTLE_CYC(SET_CYC)) i_cbes_top (
    .clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i), .clock_in_i(clock_in_i),
    .output_mode_select_low(sel_lo), .output_mode_select_high(sel_hi),
    .diff_clock_out_true(d_true), .diff_clock_out_comp(d_comp), .diff_oe_o(d_oe),
    .single_ended_clock_out(se_out), .se_oe_o(se_oe), .settling_o(settling));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_change();
    logic last;
    last = clock_in_i;
    while (clock_in_i === last) @(negedge clock_i);
    repeat (3) @(negedge clock_i);
  endtask
  // Idle after reset: drivers off, true low, complement high.
  task automatic t_idle();
    check({6'h00, d_oe, se_oe}, 8'h00);
    check({5'h00, d_true, d_comp, settling}, 8'h02);
  endtask
  // Enable rise: settle with both legs high, then low, then follow the input.
  task automatic t_enable();
    int n;
    enable_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check({5'h00, d_oe, settling, d_true & d_comp}, 8'h07);
    n = 1;
    while (settling === 1'b1 && n < SET_CYC + 3) begin
      @(negedge clock_i);
      n++;
    end
    check(8'(n <= SET_CYC), 8'h01);
    check({5'h00, d_true, d_comp, se_out}, 8'h02);
    // An input edge latched on the step into run is only followed from the next edge on.
    wait_change();
    for (int k = 0; k < 6; k++) begin
      wait_change();
      check({6'h00, d_true, d_comp}, {6'h00, clock_in_i, ~clock_in_i});
      check({7'h00, se_out}, {7'h00, clock_in_i});
    end
  endtask
  // Divide by two on the differential leg while the other driver is switched.
  task automatic t_divide();
    logic prev;
    sel_lo = cbes_pkg::SEL_MID;
    while (clock_in_i !== 1'b1) @(negedge clock_i);
    wait_change();
    wait_change();
    for (int k = 0; k < 4; k++) begin
      sel_hi = k[0] ? cbes_pkg::SEL_MID : cbes_pkg::SEL_HIGH;
      repeat (2) @(negedge clock_i);
      check({7'h00, se_oe}, {7'h00, k[0]});
      if (k[0] == 1'b1) begin
        check({7'h00, se_out}, {7'h00, d_true});
      end
      prev = d_true;
      wait_change();
      wait_change();
      check({7'h00, d_true}, {7'h00, ~prev});
      check({7'h00, d_comp}, {7'h00, prev});
    end
    sel_lo = cbes_pkg::SEL_LOW;
    sel_hi = cbes_pkg::SEL_LOW;
  endtask
  // Enable fall: drivers off two edges later, select changes ignored while off.
  task automatic t_disable();
    enable_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check({6'h00, d_oe, se_oe}, 8'h00);
    sel_lo = cbes_pkg::SEL_MID;
    sel_hi = cbes_pkg::SEL_MID;
    repeat (10) @(negedge clock_i);
    check({3'h0, d_oe, se_oe, settling, d_true, d_comp}, 8'h01);
    sel_lo = cbes_pkg::SEL_LOW;
    sel_hi = cbes_pkg::SEL_LOW;
  endtask
  initial begin
    repeat (6) @(negedge clock_i);
    reset_i = 1'b0;
    @(negedge clock_i);
    t_idle();
    t_enable();
    t_divide();
    t_disable();
    t_enable();
    t_disable();
    end_sim();
  end
  // The tests need well under a thousand cycles; four thousand means a hang.
  initial begin
    #(4000 * 50);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
